// ---- area_guard.sv ----
// Decodes whether a write or erase target lies in a protected area
`timescale 1ns/1ps
`include "flash_guard_defs.svh"
module area_guard (
    // Protection settings
    input  wire logic [2:0]  level,
    input  wire logic        otp_mode,
    input  wire logic        otp_lock,
    // Target
    input  wire logic [23:0] addr,
    input  wire logic        whole_chip,
    // Verdict
    output logic             hit
);
    logic [23:0] area_end;   // Last protected address
    logic        level_hit;  // Target inside the lower region

    // Upper end of the protected region for each level
    assign area_end = (level == 3'h1) ? `PROT_END_1 :
                      (level == 3'h2) ? `PROT_END_2 :
                      (level == 3'h3) ? `PROT_END_3 :
                      (level == 3'h4) ? `PROT_END_4 :
                      (level == 3'h5) ? `PROT_END_5 : `PROT_END_6;

    // Level 0 guards nothing, level 7 everything
    assign level_hit = (level == 3'h0) ? 1'b0 :
                       (level == 3'h7) ? 1'b1 :
                       whole_chip | (addr <= area_end);

    // The one-time sector is guarded only by its own lock
    assign hit = otp_mode ? otp_lock : level_hit;
endmodule

// ---- flash_guard.sv ----
// Power states, status register and write protection of a serial flash
//
// Summary of operation
// - Select low means device active
// - After select high, stay active until idle
// - Deep sleep until wake instruction
// - Deep sleep ignores all but wake
// - Busy bit shows running internal cycle
// - Modifying instructions need write enable latch
// - Latch clears at reset and completions
// - Protect level bits non-volatile, size region
// - Writes into protected region refused
// - Protect level code maps region ends
// - Pin disable bit defeats protect pin
// - Pin mode makes lock, level read-only
// - One-time mode: lock bit gates sector
// - Set one-time lock clears only at reset
// - One-time status write just sets lock
// - Write instructions need whole-byte frames
// - Writes blocked during power-up wait
`timescale 1ns/1ps
`include "flash_guard_defs.svh"
module flash_guard #(
    parameter int STATUS_CYCLES = `STATUS_CYCLES,
    parameter int PAGE_CYCLES   = `PAGE_CYCLES,
    parameter int ERASE_CYCLES  = `ERASE_CYCLES,
    parameter logic [7:0] DEVICE_ID = 8'h5A   // Arbitrary identity value
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Serial link pins
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe,
    // Protect pin
    input  wire logic       wp_n,
    // Device state
    output flash_guard_pkg::power_state_t power_state,
    output logic            write_in_progress,
    output logic            otp_mode,
    // Internal cycle start towards the array
    output logic            op_start,
    output flash_guard_pkg::op_kind_t op_kind,
    output logic [23:0]     op_addr
);

    // ==========================================================
    // Pin synchronisation
    pin_if pins ();

    pin_sync u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .sclk_pin (sclk),
        .cs_n_pin (cs_n),
        .mosi_pin (mosi),
        .wp_n_pin (wp_n),
        .pins     (pins.src)
    );

    // ==========================================================
    // Frame tracking
    logic       sclk_q;       // Previous serial clock level
    logic       cs_q;         // Previous select level
    logic [2:0] bit_cnt;      // Bit within current byte
    logic [8:0] byte_cnt;     // Whole bytes in frame, saturating
    logic [7:0] shift_in;     // Incoming bits
    logic [7:0] opcode;       // First byte of frame
    logic [23:0] addr;        // Address bytes
    logic [7:0] data_byte;    // Second byte, status data

    wire in_frame  = ~pins.cs_n;
    wire sclk_rise = pins.sclk & ~sclk_q;
    wire sclk_fall = ~pins.sclk & sclk_q;
    wire frame_end = pins.cs_n & ~cs_q;
    wire byte_done = in_frame & sclk_rise & (bit_cnt == 3'h7);
    wire [7:0] new_byte = {shift_in[6:0], pins.mosi};

    // Edge history of the synchronised pins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
        end else begin
            sclk_q <= pins.sclk;
            cs_q   <= pins.cs_n;
        end
    end

    // Bit and byte counting, cleared while deselected
    always_ff @(posedge clock) begin
        if (!rst_n || !in_frame) begin
            bit_cnt  <= 3'h0;
            byte_cnt <= 9'h000;
        end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7 && byte_cnt != 9'h1FF) begin
                byte_cnt <= byte_cnt + 9'h001;
            end
        end
    end

    // Capture of the instruction, address and data bytes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shift_in  <= 8'h00;
            opcode    <= 8'h00;
            addr      <= 24'h000000;
            data_byte <= 8'h00;
        end else if (in_frame && sclk_rise) begin
            shift_in <= new_byte;
            if (byte_done && byte_cnt == 9'h000) begin
                opcode <= new_byte;
            end
            if (byte_done && byte_cnt >= 9'h001 && byte_cnt <= 9'h003) begin
                addr <= {addr[15:0], new_byte};
            end
            if (byte_done && byte_cnt == 9'h001) begin
                data_byte <= new_byte;
            end
        end
    end

    // ==========================================================
    // Status bits and protection state
    logic       write_enable_latch; // Write enable latch
    logic [2:0] level;        // Protect level, non-volatile
    logic       pin_dis;      // Protect pin disable, non-volatile
    logic       lock;         // Status lock, non-volatile
    logic       otp_lock;     // One-time sector lock
    logic       busy;         // Internal cycle running
    logic [15:0] busy_cnt;    // Cycles left in internal cycle
    logic [7:0] held_data;    // Status data kept for the cycle
    logic       puw_done;     // Power-up wait over
    logic [15:0] puw_cnt;     // Power-up wait counter
    logic       deep;         // In deep power-down

    // Pin protection needs lock set, pin low and pin honoured
    wire pin_prot = lock & ~pins.wp_n & ~pin_dis;

    // Lock position shows the one-time lock in one-time mode
    wire lock_view = otp_mode ? otp_lock : lock;

    wire [7:0] status_byte = {lock_view, pin_dis, 1'b0, level, write_enable_latch, busy};

    // ==========================================================
    // Instruction decode at frame end
    wire aligned = (bit_cnt == 3'h0);
    wire one_byte = aligned & (byte_cnt == 9'h001);
    wire ready = ~busy & puw_done & ~deep;

    wire is_unlock = (opcode == `OPC_WRITE_UNLOCK);
    wire is_lock   = (opcode == `OPC_WRITE_LOCK);
    wire is_swrite = (opcode == `OPC_STATUS_WRITE);
    wire is_page   = (opcode == `OPC_PAGE_WRITE);
    wire is_four_k = (opcode == `OPC_FOUR_K_WIPE);
    wire is_block  = (opcode == `OPC_BLOCK_WIPE);
    wire is_chip   = (opcode == `OPC_CHIP_WIPE_A) | (opcode == `OPC_CHIP_WIPE_B);
    wire is_sleep  = (opcode == `OPC_DEEP_SLEEP);
    wire is_wake   = (opcode == `OPC_WAKE_READ_ID);
    wire is_otp    = (opcode == `OPC_OTP_ENTER);
    wire is_sread  = (opcode == `OPC_STATUS_READ);

    // Area check for the pending target
    logic area_hit;

    area_guard u_guard (
        .level      (level),
        .otp_mode   (otp_mode),
        .otp_lock   (otp_lock),
        .addr       (addr),
        .whole_chip (is_chip),
        .hit        (area_hit)
    );

    // Accepted instructions; all modifying ones need the latch
    wire cmd_ok    = frame_end & ready;
    wire do_unlock = cmd_ok & one_byte & is_unlock;
    wire do_lock   = cmd_ok & one_byte & is_lock;
    wire do_sleep  = cmd_ok & one_byte & is_sleep;
    wire do_otp    = cmd_ok & one_byte & is_otp;
    wire do_wake   = frame_end & deep & is_wake & (byte_cnt != 9'h000);
    wire go_status = cmd_ok & write_enable_latch & aligned & (byte_cnt == 9'h002) & is_swrite
                     & ~pin_prot;
    wire go_page   = cmd_ok & write_enable_latch & aligned & (byte_cnt >= 9'h005) & is_page
                     & ~area_hit;
    wire go_four_k = cmd_ok & write_enable_latch & aligned & (byte_cnt == 9'h004) & is_four_k
                     & ~area_hit;
    wire go_block  = cmd_ok & write_enable_latch & aligned & (byte_cnt == 9'h004) & is_block
                     & ~area_hit;
    wire go_chip   = cmd_ok & write_enable_latch & one_byte & is_chip & ~area_hit;
    wire go_any    = go_status | go_page | go_four_k | go_block | go_chip;

    // Kind of cycle being started
    wire flash_guard_pkg::op_kind_t next_kind =
        go_status ? flash_guard_pkg::OP_STATUS :
        go_page   ? flash_guard_pkg::OP_PAGE   :
        go_four_k ? flash_guard_pkg::OP_FOUR_K :
        go_block  ? flash_guard_pkg::OP_BLOCK  :
        go_chip   ? flash_guard_pkg::OP_CHIP   : flash_guard_pkg::OP_NONE;

    // Cycle length for each kind
    logic [15:0] next_len;
    always_comb begin
        case (next_kind)
            flash_guard_pkg::OP_STATUS: next_len = 16'(STATUS_CYCLES - 1);
            flash_guard_pkg::OP_PAGE:   next_len = 16'(PAGE_CYCLES - 1);
            flash_guard_pkg::OP_NONE:   next_len = 16'h0000;
            default:                    next_len = 16'(ERASE_CYCLES - 1);
        endcase
    end

    wire cycle_done = busy & (busy_cnt == 16'h0000);

    // ==========================================================
    // Power-up wait; no modifying instruction before it ends
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            puw_cnt  <= 16'h0000;
            puw_done <= 1'b0;
        end else if (!puw_done) begin
            puw_cnt  <= puw_cnt + 16'h0001;
            puw_done <= (puw_cnt == 16'(`PUW_CYCLES - 1));
        end
    end

    // Internal cycle timer drives the busy bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy      <= 1'b0;
            busy_cnt  <= 16'h0000;
            held_data <= 8'h00;
        end else if (go_any) begin
            busy      <= 1'b1;
            busy_cnt  <= next_len;
            held_data <= data_byte;
        end else if (cycle_done) begin
            busy <= 1'b0;
        end else if (busy) begin
            busy_cnt <= busy_cnt - 16'h0001;
        end
    end

    // Write enable latch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            write_enable_latch <= 1'b0;
        end else if (cycle_done || do_lock) begin
            write_enable_latch <= 1'b0;
        end else if (do_unlock) begin
            write_enable_latch <= 1'b1;
        end
    end

    // Non-volatile bits change only when a status cycle ends
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            level    <= `LEVEL_RESET;
            pin_dis  <= `PIN_DIS_RESET;
            lock     <= `LOCK_RESET;
            otp_lock <= 1'b0;
        end else if (cycle_done && op_kind == flash_guard_pkg::OP_STATUS) begin
            if (otp_mode) begin
                otp_lock <= 1'b1;
            end else begin
                level   <= held_data[`SR_LEVEL_MSB:`SR_LEVEL_LSB];
                pin_dis <= held_data[`SR_PIN_DIS_BIT];
                lock    <= held_data[`SR_LOCK_BIT];
            end
        end
    end

    // One-time mode entry and exit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            otp_mode <= 1'b0;
        end else if (do_otp) begin
            otp_mode <= 1'b1;
        end else if (do_lock) begin
            otp_mode <= 1'b0;
        end
    end

    // Deep power-down entry and release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            deep <= 1'b0;
        end else if (do_sleep) begin
            deep <= 1'b1;
        end else if (do_wake) begin
            deep <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs of state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            power_state <= flash_guard_pkg::PWR_STANDBY;
        end else if (deep) begin
            power_state <= flash_guard_pkg::PWR_DEEP;
        end else if (in_frame || busy) begin
            power_state <= flash_guard_pkg::PWR_ACTIVE;
        end else begin
            power_state <= flash_guard_pkg::PWR_STANDBY;
        end
    end

    // Busy bit mirrored to a pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            write_in_progress <= 1'b0;
        end else begin
            write_in_progress <= busy;
        end
    end

    // Start pulse and target of each accepted cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            op_start <= 1'b0;
            op_kind  <= flash_guard_pkg::OP_NONE;
            op_addr  <= 24'h000000;
        end else begin
            op_start <= go_any;
            if (go_any) begin
                op_kind <= next_kind;
                op_addr <= addr;
            end
        end
    end

    // ==========================================================
    // Serial output of status and identity
    logic [7:0] tx;               // Outgoing bits
    wire rd_status = is_sread & ~deep & (byte_cnt != 9'h000);
    wire rd_id     = is_wake & (byte_cnt >= 9'h004);
    wire [7:0] tx_src = rd_status ? status_byte :
                        rd_id     ? DEVICE_ID   : 8'h00;

    // Bits change on falling serial clock, reload each byte
    always_ff @(posedge clock) begin
        if (!rst_n || !in_frame) begin
            tx      <= 8'h00;
            miso    <= 1'b0;
            miso_oe <= 1'b0;
        end else if (sclk_fall) begin
            miso_oe <= rd_status | rd_id;
            if (bit_cnt == 3'h0) begin
                miso <= tx_src[7];
                tx   <= {tx_src[6:0], 1'b0};
            end else begin
                miso <= tx[7];
                tx   <= {tx[6:0], 1'b0};
            end
        end
    end

endmodule

// ---- flash_guard_checker.sv ----
// Concurrent checks on the ports of the flash power and protection block
`timescale 1ns/1ps
`include "flash_guard_defs.svh"
module flash_guard_checker #(
    parameter int STATUS_CYCLES = 4,
    parameter int PAGE_CYCLES   = 8,
    parameter int ERASE_CYCLES  = 16
) (
    // Clock and reset
    input wire logic                          clock,
    input wire logic                          rst_n,
    // Link select
    input wire logic                          cs_n,
    // Observed outputs
    input wire logic                          miso_oe,
    input wire flash_guard_pkg::power_state_t power_state,
    input wire logic                          write_in_progress,
    input wire logic                          op_start,
    input wire flash_guard_pkg::op_kind_t     op_kind
);
    // ======================================
    // Helper counters
    logic [15:0] run_len;   // Cycles the busy flag has stood
    logic [11:0] since_rst; // Cycles since reset release, saturating
    int          exp_len;   // Busy length expected for the running kind
    assign exp_len = (op_kind == flash_guard_pkg::OP_STATUS) ? STATUS_CYCLES :
                     (op_kind == flash_guard_pkg::OP_PAGE) ? PAGE_CYCLES : ERASE_CYCLES;
    // Count busy run and time since reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_len   <= 16'h0000;
            since_rst <= 12'h000;
        end else begin
            run_len <= write_in_progress ? run_len + 16'h0001 : 16'h0000;
            if (since_rst != 12'hFFF) begin
                since_rst <= since_rst + 12'h001;
            end
        end
    end
    // ======================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_idle_out;
        (cs_n && !write_in_progress && power_state != flash_guard_pkg::PWR_DEEP)[*8];
    endsequence
    sequence s_busy_out;
        (cs_n && write_in_progress)[*2];
    endsequence
    chk_select_active: assert property ((!cs_n)[*4] |-> power_state != flash_guard_pkg::PWR_STANDBY)
        else $error("device not active while selected");
    chk_oe_released: assert property (cs_n[*6] |-> !miso_oe)
        else $error("output driven while deselected");
    chk_busy_stays_active: assert property (s_busy_out |-> power_state == flash_guard_pkg::PWR_ACTIVE)
        else $error("left active state while busy");
    chk_idle_standby: assert property (s_idle_out |-> power_state == flash_guard_pkg::PWR_STANDBY)
        else $error("no standby when idle and deselected");
    chk_deep_quiet: assert property (power_state == flash_guard_pkg::PWR_DEEP |-> !op_start)
        else $error("cycle started in deep sleep");
    chk_start_sets_busy: assert property (op_start |=> write_in_progress)
        else $error("busy flag missing after start");
    chk_start_when_idle: assert property (op_start |-> !write_in_progress)
        else $error("cycle started while busy");
    chk_busy_length: assert property ($fell(write_in_progress) |-> run_len == exp_len)
        else $error("busy length wrong");
    chk_start_after_frame: assert property (op_start |-> cs_n && $past(cs_n, 2))
        else $error("cycle started inside a frame");
    chk_powerup_block: assert property (since_rst < `PUW_CYCLES |-> !op_start)
        else $error("cycle started in power-up wait");
endmodule
bind flash_guard flash_guard_checker #(
    .STATUS_CYCLES(STATUS_CYCLES),
    .PAGE_CYCLES  (PAGE_CYCLES),
    .ERASE_CYCLES (ERASE_CYCLES)
) chk (
    .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .miso_oe(miso_oe),
    .power_state(power_state), .write_in_progress(write_in_progress),
    .op_start(op_start), .op_kind(op_kind)
);

// ---- flash_guard_defs.svh ----
// Constants for the flash power and write-protection block
`ifndef FLASH_GUARD_DEFS_SVH
`define FLASH_GUARD_DEFS_SVH

// ==========================================================
// Status register field positions
`define SR_BUSY_BIT     0
`define SR_LATCH_BIT    1
`define SR_LEVEL_LSB    2
`define SR_LEVEL_MSB    4
`define SR_PIN_DIS_BIT  6
`define SR_LOCK_BIT     7

// ==========================================================
// Reset values of the non-volatile bits
`define LEVEL_RESET     3'h0
`define PIN_DIS_RESET   1'h0
`define LOCK_RESET      1'h0

// ==========================================================
// Instruction codes
`define OPC_WRITE_UNLOCK 8'h06
`define OPC_WRITE_LOCK   8'h04
`define OPC_STATUS_READ  8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_PAGE_WRITE   8'h02
`define OPC_FOUR_K_WIPE  8'h20
`define OPC_BLOCK_WIPE   8'hD8
`define OPC_CHIP_WIPE_A  8'hC7
`define OPC_CHIP_WIPE_B  8'h60
`define OPC_DEEP_SLEEP   8'hB9
`define OPC_WAKE_READ_ID 8'hAB
`define OPC_OTP_ENTER    8'h3A

// ==========================================================
// Upper ends of the protected lower regions, codes 1 to 6
`define PROT_END_1 24'h0FDFFF
`define PROT_END_2 24'h0FBFFF
`define PROT_END_3 24'h0F7FFF
`define PROT_END_4 24'h0EFFFF
`define PROT_END_5 24'h0DFFFF
`define PROT_END_6 24'h0BFFFF

// ==========================================================
// Timing
`define CLK_PERIOD_NS   5
`define PUW_TIME_US     10
`define PUW_CYCLES      ((`PUW_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STATUS_CYCLES   200
`define PAGE_CYCLES     400
`define ERASE_CYCLES    800

`endif

// ---- flash_guard_pkg.sv ----
// Types shared by the flash power and write-protection block
package flash_guard_pkg;
    // Power state of the device
    typedef enum logic [1:0] {
        PWR_ACTIVE  = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_DEEP    = 2'b10
    } power_state_t;
    // Kind of internal write cycle
    typedef enum logic [2:0] {
        OP_NONE   = 3'b000,
        OP_STATUS = 3'b001,
        OP_PAGE   = 3'b010,
        OP_FOUR_K = 3'b011,
        OP_BLOCK  = 3'b100,
        OP_CHIP   = 3'b101
    } op_kind_t;
endpackage

// ---- pin_if.sv ----
// Synchronised serial pins passed from the synchroniser to the core
`timescale 1ns/1ps
interface pin_if;
    logic sclk;     // Serial clock level
    logic cs_n;     // Select, low active
    logic mosi;     // Serial data in
    logic wp_n;     // Write protect pin, low active
    // Synchroniser side
    modport src (output sclk, output cs_n, output mosi, output wp_n);
    // Core side
    modport dst (input sclk, input cs_n, input mosi, input wp_n);
endinterface

// ---- pin_sync.sv ----
// Two-stage synchronisers for the serial pins
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Raw pins
    input  wire logic sclk_pin,
    input  wire logic cs_n_pin,
    input  wire logic mosi_pin,
    input  wire logic wp_n_pin,
    // Synchronised levels
    pin_if.src        pins
);
    logic [3:0] stage1;   // First stage, read only by stage2
    logic [3:0] stage2;   // Second stage, safe to use

    // Two flip-flops per pin; select and protect idle high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1 <= 4'hA;
            stage2 <= 4'hA;
        end else begin
            stage1 <= {wp_n_pin, mosi_pin, cs_n_pin, sclk_pin};
            stage2 <= stage1;
        end
    end

    // Hand out the second stage
    assign pins.sclk = stage2[0];
    assign pins.cs_n = stage2[1];
    assign pins.mosi = stage2[2];
    assign pins.wp_n = stage2[3];
endmodule

// ---- spi_host_model.sv ----
// Serial host model: mode 0 frames, 125 ns link clock
`timescale 1ns/1ps
module spi_host_model (
    // System clock for pacing
    input  wire logic clock,
    // Link pins
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    logic [63:0] rx; // Bits from the device, newest in bit 0
    // Idle link: clock low, deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        rx   = 64'h0;
    end
    // Send nbits MSB first, sample miso before each rise
    task automatic frame(input logic [63:0] tx, input int nbits);
        repeat (3) @(negedge clock);
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi = tx[63-i];                  // Change after fall
            repeat (13) @(negedge clock);
            rx   = {rx[62:0], miso};
            sclk = 1'b1;                      // Device takes data on rise
            repeat (12) @(negedge clock);
            sclk = 1'b0;
        end
        repeat (13) @(negedge clock);
        cs_n = 1'b1;
        mosi = ~mosi;                         // Data line toggled while deselected
        repeat (10) @(negedge clock);
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the flash power and protection block
`timescale 1ns/1ps
module tb_top;
    // ======================================
    // Signals
    localparam logic [7:0] DEV_ID = 8'h3C; // Arbitrary identity value
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        wp_n  = 1'b1;
    logic        sclk, cs_n, mosi, miso, miso_oe, busy, otp_mode, op_start;
    logic [1:0]  ps;
    logic [2:0]  kind, last_kind;
    logic [23:0] op_addr, last_addr;
    logic [7:0]  st;
    int          err_count = 0;
    int          cmp_count = 0;
    int          starts    = 0;
    logic [23:0] ends [8] = '{24'h0, 24'h0FDFFF, 24'h0FBFFF, 24'h0F7FFF,
                              24'h0EFFFF, 24'h0DFFFF, 24'h0BFFFF, 24'h0FFFFF};
    always #2.5 clock = ~clock;
    // ======================================
    // Design and host
    flash_guard #(.STATUS_CYCLES(4), .PAGE_CYCLES(8), .ERASE_CYCLES(16), .DEVICE_ID(DEV_ID)) dut (
        .clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .wp_n(wp_n), .power_state(ps),
        .write_in_progress(busy), .otp_mode(otp_mode), .op_start(op_start),
        .op_kind(kind), .op_addr(op_addr));
    spi_host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    // Record each started cycle
    always @(negedge clock) begin
        if (op_start === 1'b1) begin
            starts++;
            last_kind = kind;
            last_addr = op_addr;
        end
    end
    // ======================================
    // Tasks
    task complete_run;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task rd_st;
        host.frame({8'h05, 56'h0}, 16);
        st = host.rx[7:0];
    endtask
    task wen;
        host.frame({8'h06, 56'h0}, 8);
    endtask
    // Poll busy bit until clear
    task poll;
        int n;
        n = 0;
        rd_st;
        while (st[0] !== 1'b0 && n < 20) begin
            rd_st;
            n++;
        end
        check("busy", 0, st[0]);
    endtask
    // Send a frame, check the start, wait it out
    task cmd(input logic [63:0] tx, input int nbits, input logic go,
             input logic [2:0] k, input logic [23:0] a);
        int n0;
        n0 = starts;
        host.frame(tx, nbits);
        repeat (10) @(negedge clock);
        check("start", go, starts - n0);
        if (go) begin
            check("kind", k, last_kind);
            if (k >= 3'h2 && k <= 3'h4) check("addr", a, last_addr);
            poll;
            check("state", 2'h1, ps);
        end
    endtask
    task wst(input logic [7:0] d, input logic go);
        wen;
        cmd({8'h01, d, 48'h0}, 16, go, 3'h1, 24'h0);
    endtask
    // ======================================
    // Tests
    initial begin
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        wen;
        rd_st;
        check("status puw", 8'h00, st);
        repeat (2000) @(negedge clock);
        rd_st;
        check("status reset", 8'h00, st);
        $display("test power-up done");
        wen;
        rd_st;
        check("latch set", 8'h02, st);
        cmd({8'h01, 8'h1C, 48'h0}, 12, 0, 3'h1, 24'h0);
        rd_st;
        check("latch kept", 8'h02, st);
        host.frame({8'h04, 56'h0}, 8);
        rd_st;
        check("latch lock", 8'h00, st);
        cmd({8'h01, 8'h1C, 48'h0}, 16, 0, 3'h1, 24'h0);
        $display("test write enable done");
        for (int c = 1; c < 8; c++) begin
            wst({3'h0, 3'(c), 2'h0}, 1);
            rd_st;
            check("level", {3'h0, 3'(c), 2'h0}, st);
            wen;
            cmd({8'h02, ends[c], 8'hA5, 24'h0}, 40, 0, 3'h2, 24'h0);
            cmd({8'h02, ends[c] + 24'h1, 8'hA5, 24'h0}, 40, c != 7, 3'h2, ends[c] + 24'h1);
        end
        cmd({8'hC7, 56'h0}, 8, 0, 3'h5, 24'h0);
        wst(8'h00, 1);
        wen;
        cmd({8'h20, 24'h001000, 32'h0}, 32, 1, 3'h3, 24'h001000);
        wen;
        cmd({8'hD8, 24'h0F0000, 32'h0}, 32, 1, 3'h4, 24'h0F0000);
        wen;
        cmd({8'h60, 56'h0}, 8, 1, 3'h5, 24'h0);
        wen;
        cmd({8'hC7, 56'h0}, 8, 1, 3'h5, 24'h0);
        rd_st;
        check("latch clear", 8'h00, st);
        $display("test protection done");
        host.frame({8'h3A, 56'h0}, 8);
        check("otp mode", 1, otp_mode);
        wen;
        cmd({8'h02, 24'h000010, 8'h5A, 24'h0}, 40, 1, 3'h2, 24'h000010);
        wst(8'h1C, 1);
        rd_st;
        check("otp lock", 8'h80, st);
        wen;
        cmd({8'h20, 24'h0, 32'h0}, 32, 0, 3'h3, 24'h0);
        host.frame({8'h04, 56'h0}, 8);
        check("otp exit", 0, otp_mode);
        $display("test one-time done");
        host.frame({8'hB9, 56'h0}, 8);
        check("deep", 2'h2, ps);
        wen;
        cmd({8'h20, 24'h0, 32'h0}, 32, 0, 3'h3, 24'h0);
        host.frame({8'hAB, 56'h0}, 40);
        check("ident", DEV_ID, host.rx[7:0]);
        check("awake", 2'h1, ps);
        rd_st;
        check("latch deep", 8'h00, st);
        $display("test deep sleep done");
        wst(8'h84, 1);
        wp_n = 1'b0;
        wst(8'h00, 0);
        rd_st;
        check("pin held", 8'h86, st);
        wp_n = 1'b1;
        wst(8'hC0, 1);
        rd_st;
        check("pin free", 8'hC0, st);
        wp_n = 1'b0;
        wst(8'h00, 1);
        rd_st;
        check("pin off", 8'h00, st);
        $display("test pin protection done");
        complete_run;
    end
    // Watchdog cuts a hang short
    initial begin
        repeat (90000) @(negedge clock);
        err_count++;
        complete_run;
    end
endmodule
